/* File: hw/hsc_cfg_regs.vh */
// Purpose: register offsets, field positions, reset values and timing for the sensor config block
// Assumes: 8-bit register space, 125 MHz core clock
// Notes:   definitions only
`ifndef HSC_CFG_REGS_VH
`define HSC_CFG_REGS_VH

////////////////////////////////////////////////////////////////////////
// register offsets
`define HSC_ADDR_RH_UPPER     8'h0c
`define HSC_ADDR_RH_LOWER     8'h0d
`define HSC_ADDR_RATE_PIN     8'h0e
`define HSC_ADDR_MEAS_CTRL    8'h0f
`define HSC_ADDR_MAKER_LO     8'hfc
`define HSC_ADDR_MAKER_HI     8'hfd
`define HSC_ADDR_PART_LO      8'hfe
`define HSC_ADDR_PART_HI      8'hff

////////////////////////////////////////////////////////////////////////
// reset values
`define HSC_RST_RH_UPPER      8'hff
`define HSC_RST_RH_LOWER      8'h00
`define HSC_RST_RATE_PIN      8'h00
`define HSC_RST_MEAS_CTRL     8'h00
`define HSC_READ_NONE         8'h00

////////////////////////////////////////////////////////////////////////
// reset_rate_pin_control fields
`define HSC_SOFT_RESET_BIT    7
`define HSC_RATE_HI           6
`define HSC_RATE_LO           4
`define HSC_HEATER_BIT        3
`define HSC_PIN_DRIVE_BIT     2
`define HSC_POLARITY_BIT      1
`define HSC_MODE_BIT          0

////////////////////////////////////////////////////////////////////////
// measurement_control fields
`define HSC_TEMP_RES_HI       7
`define HSC_TEMP_RES_LO       6
`define HSC_RH_RES_HI         5
`define HSC_RH_RES_LO         4
`define HSC_SPARE_BIT         3
`define HSC_SEL_HI            2
`define HSC_SEL_LO            1
`define HSC_KICK_BIT          0

////////////////////////////////////////////////////////////////////////
// measure_selection codes and interrupt mask bits
`define HSC_SEL_BOTH          2'b00
`define HSC_SEL_TEMP          2'b01
`define HSC_SEL_RH            2'b10
`define HSC_MASK_DONE_BIT     7
`define HSC_MASK_RH_HIGH_BIT  4
`define HSC_MASK_RH_LOW_BIT   3

////////////////////////////////////////////////////////////////////////
// timing: one millisecond in clock cycles, sample periods in ms
`define HSC_CLK_PERIOD_NS     8
`define HSC_MS_NS             1000000
`define HSC_MS_CYCLES         (`HSC_MS_NS / `HSC_CLK_PERIOD_NS)
`define HSC_RATE_OFF          3'b000
`define HSC_PERIOD_MS_1       17'd120000
`define HSC_PERIOD_MS_2       17'd60000
`define HSC_PERIOD_MS_3       17'd10000
`define HSC_PERIOD_MS_4       17'd5000
`define HSC_PERIOD_MS_5       17'd1000
`define HSC_PERIOD_MS_6       17'd500
`define HSC_PERIOD_MS_7       17'd200

`endif

/* File: hw/hsc_rate_timer.v */
// Purpose: periodic conversion request generator driven by the sample-rate code
// Assumes: one clock, synchronous active-low reset
// Notes:   a code change restarts the period from zero
`include "hsc_cfg_regs.vh"

module hsc_rate_timer #(
    parameter MS_CYCLES = `HSC_MS_CYCLES,
    parameter PRE_W     = 17
) (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire [2:0] rate_code_in,
    output reg        tick_out
);

    ////////////////////////////////////////////////////////////////////
    // code to period in milliseconds
    function [16:0] period_ms;
        input [2:0] code;
        begin
            case (code)
                3'd1:    period_ms = `HSC_PERIOD_MS_1;
                3'd2:    period_ms = `HSC_PERIOD_MS_2;
                3'd3:    period_ms = `HSC_PERIOD_MS_3;
                3'd4:    period_ms = `HSC_PERIOD_MS_4;
                3'd5:    period_ms = `HSC_PERIOD_MS_5;
                3'd6:    period_ms = `HSC_PERIOD_MS_6;
                3'd7:    period_ms = `HSC_PERIOD_MS_7;
                default: period_ms = 17'd0;
            endcase
        end
    endfunction

    reg  [PRE_W-1:0] pre_q;
    reg  [16:0]      ms_q;
    reg  [2:0]       code_q;
    wire             ms_tick = (pre_q == MS_CYCLES[PRE_W-1:0] - 1'b1);
    wire             restart = (code_q != rate_code_in) || (rate_code_in == `HSC_RATE_OFF);

    ////////////////////////////////////////////////////////////////////
    // ms prescaler and period counter; held in reset while on demand only
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            pre_q    <= {PRE_W{1'b0}};
            ms_q     <= 17'd0;
            code_q   <= `HSC_RATE_OFF;
            tick_out <= 1'b0;
        end else begin
            code_q   <= rate_code_in;
            tick_out <= 1'b0;
            if (restart) begin
                pre_q <= {PRE_W{1'b0}};
                ms_q  <= 17'd0;
            end else if (ms_tick) begin
                pre_q <= {PRE_W{1'b0}};
                if (ms_q == period_ms(code_q) - 17'd1) begin
                    ms_q     <= 17'd0;
                    tick_out <= 1'b1;
                end else begin
                    ms_q <= ms_q + 17'd1;
                end
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

endmodule

/* File: hw/hsc_cfg_regs.v */
// Purpose: upper configuration registers of a humidity/temperature sensor, conversion
//          sequencing, humidity alarms and alert pin control
// Assumes: byte register port fed by the serial-bus front end, one clock at 125 MHz
// Notes:   interrupt mask register lives elsewhere and arrives on INT_MASK_IN
`include "hsc_cfg_regs.vh"

module hsc_cfg_regs #(
    parameter [15:0] MAKER_CODE = 16'h1234,  // arbitrary value
    parameter [15:0] PART_CODE  = 16'h5678,  // arbitrary value
    parameter        MS_CYCLES  = `HSC_MS_CYCLES
) (
    input  wire       REF_CLK_IN,
    input  wire       RST_B_IN,
    input  wire [7:0] REG_ADDR_IN,
    input  wire [7:0] REG_WDATA_IN,
    input  wire       REG_WR_IN,
    input  wire       REG_RD_IN,
    output reg  [7:0] REG_RDATA_OUT,
    input  wire [7:0] INT_MASK_IN,
    input  wire       ALERT_CLEAR_IN,
    input  wire       CONV_DONE_IN,
    input  wire [7:0] CONV_RH_IN,
    output reg        CONV_START_OUT,
    output wire       CONV_BUSY_OUT,
    output wire [1:0] CONV_SELECT_OUT,
    output wire [1:0] TEMP_RESOLUTION_OUT,
    output wire [1:0] RH_RESOLUTION_OUT,
    output wire       HEATER_ON_OUT,
    output reg        NV_RELOAD_OUT,
    output reg        RH_HIGH_ALARM_OUT,
    output reg        RH_LOW_ALARM_OUT,
    output reg        ALERT_PIN_OUT,
    output wire       ALERT_PIN_OE_B_OUT
);

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer states
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // register file and state
    reg  [7:0]  rh_upper_limit_q;
    reg  [7:0]  rh_lower_limit_q;
    reg         software_reset_bit_q;
    reg  [2:0]  sample_rate_select_q;
    reg         heater_q;
    reg         alert_pin_drive_q;
    reg         alert_polarity_q;
    reg         alert_mode_q;
    reg  [1:0]  temp_resolution_q;
    reg  [1:0]  rh_resolution_q;
    reg         spare_q;
    reg  [1:0]  measure_selection_q;
    reg         measure_kick_q;
    reg  [15:0] maker_code_q;
    reg  [15:0] part_code_q;
    reg         state_q;
    reg  [1:0]  busy_sel_q;
    reg         rh_high_latch_q;
    reg         rh_low_latch_q;
    reg         done_latch_q;
    reg  [7:0]  rdata_d;
    reg         alert_active_d;

    wire        srst;
    wire        wr_upper;
    wire        wr_lower;
    wire        wr_rate_pin;
    wire        wr_meas;
    wire        rate_tick;
    wire        start_req;
    wire        conv_end;
    wire        rh_measured;
    wire        rh_above;
    wire        rh_below;
    wire        allow_high;
    wire        allow_low;
    wire        allow_done;

    ////////////////////////////////////////////////////////////////////
    // address match, used by every write decode
    function hit;
        input [7:0] addr;
        input [7:0] target;
        input       strobe;
        begin
            hit = strobe && (addr == target);
        end
    endfunction

    // does a selection code include the humidity channel
    function has_rh;
        input [1:0] sel;
        begin
            has_rh = (sel == `HSC_SEL_BOTH) || (sel == `HSC_SEL_RH);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // soft reset acts one cycle after the write so the write itself completes
    assign srst        = !RST_B_IN || software_reset_bit_q;
    assign wr_upper    = hit(REG_ADDR_IN, `HSC_ADDR_RH_UPPER, REG_WR_IN);
    assign wr_lower    = hit(REG_ADDR_IN, `HSC_ADDR_RH_LOWER, REG_WR_IN);
    assign wr_rate_pin = hit(REG_ADDR_IN, `HSC_ADDR_RATE_PIN, REG_WR_IN);
    assign wr_meas     = hit(REG_ADDR_IN, `HSC_ADDR_MEAS_CTRL, REG_WR_IN);

    ////////////////////////////////////////////////////////////////////
    // soft reset bit: pulses for one cycle, then reads back as zero
    always @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            software_reset_bit_q <= 1'b0;
            NV_RELOAD_OUT        <= 1'b0;
        end else begin
            software_reset_bit_q <= wr_rate_pin && REG_WDATA_IN[`HSC_SOFT_RESET_BIT] && !software_reset_bit_q;
            NV_RELOAD_OUT        <= software_reset_bit_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // identification codes, reloaded from the nonvolatile image on reset
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            maker_code_q <= MAKER_CODE;
            part_code_q  <= PART_CODE;
        end else begin
            maker_code_q <= maker_code_q;
            part_code_q  <= part_code_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // humidity limits
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            rh_upper_limit_q <= `HSC_RST_RH_UPPER;
            rh_lower_limit_q <= `HSC_RST_RH_LOWER;
        end else begin
            if (wr_upper) begin
                rh_upper_limit_q <= REG_WDATA_IN;
            end
            if (wr_lower) begin
                rh_lower_limit_q <= REG_WDATA_IN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // rate, heater and alert pin configuration
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            sample_rate_select_q <= `HSC_RATE_OFF;
            heater_q             <= 1'b0;
            alert_pin_drive_q    <= 1'b0;
            alert_polarity_q     <= 1'b0;
            alert_mode_q         <= 1'b0;
        end else if (wr_rate_pin) begin
            sample_rate_select_q <= REG_WDATA_IN[`HSC_RATE_HI:`HSC_RATE_LO];
            heater_q             <= REG_WDATA_IN[`HSC_HEATER_BIT];
            alert_pin_drive_q    <= REG_WDATA_IN[`HSC_PIN_DRIVE_BIT];
            alert_polarity_q     <= REG_WDATA_IN[`HSC_POLARITY_BIT];
            alert_mode_q         <= REG_WDATA_IN[`HSC_MODE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurement configuration; undefined codes are stored as written
    // and passed on, the converter decides what they mean; the alarms treat selection 2'b11 as no humidity
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            temp_resolution_q   <= 2'b00;
            rh_resolution_q     <= 2'b00;
            spare_q             <= 1'b0;
            measure_selection_q <= `HSC_SEL_BOTH;
        end else if (wr_meas) begin
            temp_resolution_q   <= REG_WDATA_IN[`HSC_TEMP_RES_HI:`HSC_TEMP_RES_LO];
            rh_resolution_q     <= REG_WDATA_IN[`HSC_RH_RES_HI:`HSC_RH_RES_LO];
            spare_q             <= REG_WDATA_IN[`HSC_SPARE_BIT];
            measure_selection_q <= REG_WDATA_IN[`HSC_SEL_HI:`HSC_SEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurement kick: a host write of one wins over the completion clear,
    // so a request made in the completing cycle is not lost
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            measure_kick_q <= 1'b0;
        end else if (wr_meas && REG_WDATA_IN[`HSC_KICK_BIT]) begin
            measure_kick_q <= 1'b1;
        end else if (conv_end && measure_kick_q) begin
            measure_kick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // periodic request generator
    hsc_rate_timer #(
        .MS_CYCLES (MS_CYCLES),
        .PRE_W     (17)
    ) u_rate_timer (
        .clk_in       (REF_CLK_IN),
        .rst_b_in     (!srst),
        .rate_code_in (sample_rate_select_q),
        .tick_out     (rate_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer; a periodic tick that lands while busy is dropped,
    // the next period catches up rather than queueing stale samples
    assign start_req = (measure_kick_q || rate_tick) && (state_q == ST_IDLE);
    assign conv_end  = (state_q == ST_BUSY) && CONV_DONE_IN;

    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            state_q        <= ST_IDLE;
            busy_sel_q     <= `HSC_SEL_BOTH;
            CONV_START_OUT <= 1'b0;
        end else begin
            CONV_START_OUT <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_req && !CONV_START_OUT) begin
                        state_q        <= ST_BUSY;
                        busy_sel_q     <= measure_selection_q;
                        CONV_START_OUT <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    if (CONV_DONE_IN) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign CONV_BUSY_OUT       = (state_q == ST_BUSY);
    assign CONV_SELECT_OUT     = measure_selection_q;
    assign TEMP_RESOLUTION_OUT = temp_resolution_q;
    assign RH_RESOLUTION_OUT   = rh_resolution_q;
    assign HEATER_ON_OUT       = heater_q;

    ////////////////////////////////////////////////////////////////////
    // humidity alarm comparison, only for conversions that measured humidity
    assign rh_measured = conv_end && has_rh(busy_sel_q);
    assign rh_above    = CONV_RH_IN > rh_upper_limit_q;
    assign rh_below    = CONV_RH_IN < rh_lower_limit_q;

    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            RH_HIGH_ALARM_OUT <= 1'b0;
            RH_LOW_ALARM_OUT  <= 1'b0;
        end else if (rh_measured) begin
            RH_HIGH_ALARM_OUT <= rh_above;
            RH_LOW_ALARM_OUT  <= rh_below;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source enables: threshold masks are active high blocks,
    // the conversion-done mask is an active high allow
    assign allow_high = !INT_MASK_IN[`HSC_MASK_RH_HIGH_BIT];
    assign allow_low  = !INT_MASK_IN[`HSC_MASK_RH_LOW_BIT];
    assign allow_done = INT_MASK_IN[`HSC_MASK_DONE_BIT];

    ////////////////////////////////////////////////////////////////////
    // latched events for level style, done latched for both styles; new events win over the host clear
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            rh_high_latch_q <= 1'b0;
            rh_low_latch_q  <= 1'b0;
            done_latch_q    <= 1'b0;
        end else begin
            if (rh_measured && rh_above) begin
                rh_high_latch_q <= 1'b1;
            end else if (ALERT_CLEAR_IN) begin
                rh_high_latch_q <= 1'b0;
            end
            if (rh_measured && rh_below) begin
                rh_low_latch_q <= 1'b1;
            end else if (ALERT_CLEAR_IN) begin
                rh_low_latch_q <= 1'b0;
            end
            if (conv_end) begin
                done_latch_q <= 1'b1;
            end else if (ALERT_CLEAR_IN) begin
                done_latch_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alert condition: level style holds events until cleared, comparator
    // style follows the latest comparison; done is always latched
    always @* begin
        if (alert_mode_q) begin
            alert_active_d = (RH_HIGH_ALARM_OUT && allow_high) ||
                             (RH_LOW_ALARM_OUT && allow_low) ||
                             (done_latch_q && allow_done);
        end else begin
            alert_active_d = (rh_high_latch_q && allow_high) ||
                             (rh_low_latch_q && allow_low) ||
                             (done_latch_q && allow_done);
        end
    end

    // pin level registered to keep glitches off the board
    always @(posedge REF_CLK_IN) begin
        if (srst) begin
            ALERT_PIN_OUT <= 1'b1;
        end else begin
            ALERT_PIN_OUT <= alert_polarity_q ? alert_active_d : !alert_active_d;
        end
    end

    // floating unless drive is enabled; enable is active low
    assign ALERT_PIN_OE_B_OUT = !alert_pin_drive_q;

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero
    always @* begin
        case (REG_ADDR_IN)
            `HSC_ADDR_RH_UPPER:  rdata_d = rh_upper_limit_q;
            `HSC_ADDR_RH_LOWER:  rdata_d = rh_lower_limit_q;
            `HSC_ADDR_RATE_PIN:  rdata_d = {1'b0, sample_rate_select_q, heater_q,
                                            alert_pin_drive_q, alert_polarity_q, alert_mode_q};
            `HSC_ADDR_MEAS_CTRL: rdata_d = {temp_resolution_q, rh_resolution_q, spare_q,
                                            measure_selection_q, measure_kick_q};
            `HSC_ADDR_MAKER_LO:  rdata_d = maker_code_q[7:0];
            `HSC_ADDR_MAKER_HI:  rdata_d = maker_code_q[15:8];
            `HSC_ADDR_PART_LO:   rdata_d = part_code_q[7:0];
            `HSC_ADDR_PART_HI:   rdata_d = part_code_q[15:8];
            default:             rdata_d = `HSC_READ_NONE;
        endcase
    end

    // read data captured on the read strobe and held until the next one
    always @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            REG_RDATA_OUT <= `HSC_READ_NONE;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= rdata_d;
        end
    end

endmodule

/* File: dv/hsc_cfg_regs_checker.sv */
// Purpose: port properties of the config block
// Assumes: one clock, sync active-low reset
// Notes:   limit shadow ignores soft reset
module hsc_cfg_chk (
    input wire       REF_CLK_IN,
    input wire       RST_B_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire       REG_WR_IN,
    input wire       CONV_DONE_IN,
    input wire [7:0] CONV_RH_IN,
    input wire       CONV_START_OUT,
    input wire       CONV_BUSY_OUT,
    input wire [1:0] CONV_SELECT_OUT,
    input wire       HEATER_ON_OUT,
    input wire       NV_RELOAD_OUT,
    input wire       RH_HIGH_ALARM_OUT,
    input wire       RH_LOW_ALARM_OUT,
    input wire       ALERT_PIN_OE_B_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lim_q;
    wire         w_e = REG_WR_IN && REG_ADDR_IN == 8'h0e;
    wire         fin = CONV_BUSY_OUT && CONV_DONE_IN && CONV_SELECT_OUT != 2'b01;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    ////////////////////////////////////////
    // upper limit in high byte, lower in low byte
    always @(posedge REF_CLK_IN) begin
        if (!RST_B_IN)
            lim_q <= 16'hff00;
        else if (REG_WR_IN && REG_ADDR_IN[7:1] == 7'h06)
            lim_q[{~REG_ADDR_IN[0], 3'h0} +: 8] <= REG_WDATA_IN;
    end
    sequence s_nv;
        ##2 NV_RELOAD_OUT ##1 !NV_RELOAD_OUT;
    endsequence
    sequence s_go;
        ##2 CONV_START_OUT && CONV_BUSY_OUT ##1 !CONV_START_OUT;
    endsequence
    property p_heat;
        w_e && !REG_WDATA_IN[7] |=> HEATER_ON_OUT == $past(REG_WDATA_IN[3]);
    endproperty
    a_heat: assert property (p_heat) else $error("heater bit lost");
    property p_oe;
        w_e && !REG_WDATA_IN[7] |=> ALERT_PIN_OE_B_OUT != $past(REG_WDATA_IN[2]);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_kick;
        REG_WR_IN && REG_ADDR_IN == 8'h0f && REG_WDATA_IN[0] && !CONV_BUSY_OUT |-> s_go;
    endproperty
    a_kick: assert property (p_kick) else $error("no start after kick");
    property p_one;
        CONV_START_OUT |=> !CONV_START_OUT;
    endproperty
    a_one: assert property (p_one) else $error("start too long");
    property p_fin;
        CONV_BUSY_OUT && CONV_DONE_IN |=> !CONV_BUSY_OUT;
    endproperty
    a_fin: assert property (p_fin) else $error("busy after done");
    property p_high;
        fin |=> RH_HIGH_ALARM_OUT == ($past(CONV_RH_IN) > lim_q[15:8]);
    endproperty
    a_high: assert property (p_high) else $error("high alarm wrong");
    property p_low;
        fin |=> RH_LOW_ALARM_OUT == ($past(CONV_RH_IN) < lim_q[7:0]);
    endproperty
    a_low: assert property (p_low) else $error("low alarm wrong");
    property p_nv;
        w_e && REG_WDATA_IN[7] |-> s_nv;
    endproperty
    a_nv: assert property (p_nv) else $error("no reload pulse");
endmodule
bind hsc_cfg_regs hsc_cfg_chk hsc_cfg_chk_i (.REF_CLK_IN, .RST_B_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
    .CONV_DONE_IN, .CONV_RH_IN, .CONV_START_OUT, .CONV_BUSY_OUT, .CONV_SELECT_OUT, .HEATER_ON_OUT,
    .NV_RELOAD_OUT, .RH_HIGH_ALARM_OUT, .RH_LOW_ALARM_OUT, .ALERT_PIN_OE_B_OUT);

/* File: dv/hsc_conv_model.sv */
// Purpose: converter stand-in answering start pulses
// Assumes: start is a one-cycle pulse
// Notes:   result bus toggles outside the done cycle
module hsc_conv_model (
    input  wire        clk_in,
    input  wire        start_in,
    input  wire  [7:0] rh_in,
    input  wire  [7:0] lag_in,
    output logic       done_out = 1'b0,
    output logic [7:0] rh_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    logic       run_q = 1'b0;
    ////////////////////////////////////////
    // one done per start, lag cycles late; stale result never held
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        rh_out <= ~rh_out;
        cnt_q <= start_in ? lag_in : cnt_q - 8'h01;
        if (start_in)
            run_q <= 1'b1;
        else if (run_q && cnt_q == 8'h00) begin
            run_q <= 1'b0;
            done_out <= 1'b1;
            rh_out <= rh_in;
        end
    end
endmodule

/* File: dv/hsc_cfg_regs_tb.sv */
// Purpose: self-checking bench for the config block
// Assumes: 8 ns clock, short millisecond parameter
// Notes:   read bytes checked from a queue of notes
module hsc_cfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 2; // keeps rate periods short
    logic REF_CLK_IN = 1'b0, RST_B_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0, ALERT_CLEAR_IN = 1'b0;
    logic [7:0] REG_ADDR_IN = 8'h00, REG_WDATA_IN = 8'h00, INT_MASK_IN = 8'h00, rh_v = 8'h00, lag_v = 8'h00;
    wire  [7:0] REG_RDATA_OUT, CONV_RH_IN;
    wire  [1:0] CONV_SELECT_OUT, TEMP_RESOLUTION_OUT, RH_RESOLUTION_OUT;
    wire        CONV_DONE_IN, CONV_START_OUT, CONV_BUSY_OUT, HEATER_ON_OUT, NV_RELOAD_OUT;
    wire        RH_HIGH_ALARM_OUT, RH_LOW_ALARM_OUT, ALERT_PIN_OUT, ALERT_PIN_OE_B_OUT;
    logic [31:0] seed = 32'hddf43311;
    logic [7:0] exp_q[$];
    logic       rd_p = 1'b0;
    logic [7:0] ra[9] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'h10};
    logic [7:0] rv[9] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h9a, 8'h71, 8'h4e, 8'h00};
    logic [7:0] rhs[5] = '{8'h81, 8'h80, 8'h1f, 8'h20, 8'h50};
    int         per[3] = '{200, 500, 1000};
    int         err_count = 0, total_checks = 0, n;
    // codes are arbitrary
    hsc_cfg_regs #(.MAKER_CODE(16'h9a3c), .PART_CODE(16'h4e71), .MS_CYCLES(MSC)) hsc_cfg_regs_i (.*);
    hsc_conv_model hsc_conv_model_i (.clk_in(REF_CLK_IN), .start_in(CONV_START_OUT), .rh_in(rh_v),
        .lag_in(lag_v), .done_out(CONV_DONE_IN), .rh_out(CONV_RH_IN));
    initial forever #4 REF_CLK_IN = ~REF_CLK_IN;
    ////////////////////////////////////////
    // read byte lands one cycle after its strobe
    always @(posedge REF_CLK_IN) rd_p <= REG_RD_IN;
    always @(negedge REF_CLK_IN) if (rd_p) chk(REG_RDATA_OUT, exp_q.pop_front());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge REF_CLK_IN);
        #1;
    endtask
    // one register access; a read notes its expected byte
    task automatic acc(input logic w, input logic [7:0] a, d);
        step(1);
        REG_ADDR_IN = a;
        REG_WDATA_IN = d;
        if (!w) exp_q.push_back(d);
        {REG_WR_IN, REG_RD_IN} = {w, !w};
        step(1);
        {REG_WR_IN, REG_RD_IN} = 2'b00;
    endtask
    task automatic wait_go(input int lim, input logic must, output int c);
        for (c = 0; CONV_START_OUT !== 1'b1 && c < lim; c++) step(1);
        if (must && c == lim) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic conv(input logic [7:0] rh, lag);
        rh_v = rh;
        lag_v = lag;
        acc(1'b1, 8'h0f, 8'h01);
        step(2);
        for (n = 0; CONV_BUSY_OUT === 1'b1 && n < 300; n++) step(1);
        if (n == 300) begin
            err_count++;
            close_out();
        end
    endtask
    initial begin
        step(5);
        RST_B_IN = 1'b1;
        chk({ALERT_PIN_OUT, ALERT_PIN_OE_B_OUT}, 2'b11);
        foreach (ra[i]) acc(1'b0, ra[i], rv[i]);
        acc(1'b1, 8'hfc, 8'h00);
        acc(1'b0, 8'hfc, 8'h3c);
        repeat (4) begin
            seed = lfsr(seed);
            acc(1'b1, 8'h0c, seed[7:0]);
            acc(1'b1, 8'h0d, seed[15:8]);
            acc(1'b1, 8'h0f, seed[23:16] & 8'hfe);
            acc(1'b1, 8'h0e, seed[31:24] & 8'h0f);
            acc(1'b0, 8'h0c, seed[7:0]);
            acc(1'b0, 8'h0d, seed[15:8]);
            acc(1'b0, 8'h0f, seed[23:16] & 8'hfe);
            acc(1'b0, 8'h0e, seed[31:24] & 8'h0f);
            chk({TEMP_RESOLUTION_OUT, RH_RESOLUTION_OUT, CONV_SELECT_OUT}, {seed[23:20], seed[18:17]});
            chk({HEATER_ON_OUT, ALERT_PIN_OE_B_OUT}, {seed[27], !seed[26]});
        end
        acc(1'b1, 8'h0e, 8'h06);
        acc(1'b1, 8'h0f, 8'h00);
        acc(1'b1, 8'h0c, 8'h80);
        acc(1'b1, 8'h0d, 8'h20);
        INT_MASK_IN = 8'h18;
        foreach (rhs[i]) begin
            seed = lfsr(seed);
            conv(rhs[i], i[0] ? seed[7:0] & 8'h3f : 8'h00);
            chk({RH_HIGH_ALARM_OUT, RH_LOW_ALARM_OUT}, {rhs[i] > 8'h80, rhs[i] < 8'h20});
            step(2);
            chk(ALERT_PIN_OUT, 1'b0);
            acc(1'b0, 8'h0f, 8'h00);
        end
        INT_MASK_IN = 8'h98;
        conv(8'h50, 8'h03);
        step(2);
        chk(ALERT_PIN_OUT, 1'b1);
        ALERT_CLEAR_IN = 1'b1;
        step(1);
        ALERT_CLEAR_IN = 1'b0;
        step(2);
        chk(ALERT_PIN_OUT, 1'b0);
        acc(1'b1, 8'h0e, 8'h05);
        INT_MASK_IN = 8'h08;
        conv(8'h90, 8'h00);
        step(2);
        chk({ALERT_PIN_OUT, ALERT_PIN_OE_B_OUT}, 2'b00);
        conv(8'h50, 8'h00);
        step(2);
        chk(ALERT_PIN_OUT, 1'b1);
        foreach (per[i]) begin
            acc(1'b1, 8'h0e, {1'b0, 3'(7 - i), 4'h0});
            wait_go(per[i] * MSC + 9, 1'b1, n);
            step(1);
            wait_go(per[i] * MSC + 9, 1'b1, n);
            chk(n + 1, per[i] * MSC);
        end
        acc(1'b1, 8'h0e, 8'h00);
        step(3);
        wait_go(2500, 1'b0, n);
        chk(n, 2500);
        acc(1'b1, 8'h0e, 8'h88);
        step(3);
        acc(1'b0, 8'h0c, 8'hff);
        acc(1'b0, 8'h0e, 8'h00);
        chk(HEATER_ON_OUT, 1'b0);
        step(2);
        close_out();
    end
endmodule
